/* design/fdcp_pkg.sv */
// Constants and types of the idle and drive polling sequencer
package fdcp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_MHZ = 125;            // System clock rate
  localparam int POLL_INTERVAL_US = 1000;  // Polling interval at 500 kb/s
  localparam int POLL_CYC_500 = POLL_INTERVAL_US * CLK_MHZ;
  localparam int PDOWN_DELAY_MS = 512;     // Delay after motor-off time
  localparam int PDOWN_POLLS = PDOWN_DELAY_MS * 1000 / POLL_INTERVAL_US;

  ////////////////////////////////////////////////////////////////////////////
  // Main status register layout and values
  localparam int STAT_REQ_BIT = 7;         // request_for_master_flag
  localparam int STAT_DIR_BIT = 6;         // transfer_direction_flag
  localparam int STAT_BUSY_BIT = 4;        // Command in progress
  localparam logic [7:0] STAT_IDLE = 8'h80;
  localparam logic [7:0] STAT_CMD = 8'h10;
  localparam logic [7:0] STAT_PDOWN = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Data rate codes
  localparam logic [1:0] RATE_500K = 2'h0;
  localparam logic [1:0] RATE_300K = 2'h1;
  localparam logic [1:0] RATE_250K = 2'h2;
  localparam logic [1:0] RATE_1M = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [3:0] RDY_CHG_RST = 4'hf;
  localparam logic [3:0] FILT_RST = 4'h1;

  // Sequencer phases
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_POLL = 4'h2,
    ST_CMD = 4'h4,
    ST_PDOWN = 4'h8
  } fdcp_state_e;

endpackage

/* design/fdcp_idle_poll.sv */
// Idle phase, drive polling and separator control of the disk controller
`timescale 1ns/10ps
module fdcp_idle_poll #(
  parameter int POLL_CYCLES = fdcp_pkg::POLL_CYC_500,
  parameter int CNT_W = 20,
  parameter int PD_W = 11
) (
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  input wire logic SOFT_RESET_I,
  input wire logic PDOWN_RECOVER_I,
  input wire logic OPCODE_WR_I,
  input wire logic CMD_DONE_I,
  input wire logic [1:0] RATE_SEL_I,
  input wire logic POLL_DISABLE_I,
  input wire logic AUTO_PDOWN_EN_I,
  input wire logic MOTOR_OFF_EXPIRED_I,
  input wire logic [3:0] STEP_REQ_I,
  input wire logic [3:0] STEP_DIR_I,
  input wire logic [3:0] RDY_CHG_CLR_I,
  input wire logic ID_SEARCH_I,
  input wire logic NON_PREAMBLE_LOCK_I,
  output logic [7:0] MAIN_STATUS_O,
  output logic [3:0] PHASE_O,
  output logic [3:0] READY_CHANGED_O,
  output logic POLL_IRQ_O,
  output logic [1:0] IRQ_DRIVE_O,
  output logic STEP_O,
  output logic DIR_O,
  output logic PDOWN_O,
  output logic SEP_REF_LOCK_O,
  output logic [3:0] FILTER_SEL_O
);

  ////////////////////////////////////////////////////////////////////////////
  // State and derived constants
  typedef struct packed {
    fdcp_pkg::fdcp_state_e state;
    logic [CNT_W-1:0] poll_cnt;
    logic [1:0] drv;
    logic [PD_W-1:0] pd_cnt;
    logic [3:0] rdy_chg;
    logic irq;
    logic step;
    logic dir;
    logic [7:0] stat;
    logic pdown;
    logic [1:0] irq_drv;
    logic sep_ref;
    logic [3:0] filt;
  } fdcp_regs_s;

  localparam logic [CNT_W-1:0] RLD_500 = CNT_W'(POLL_CYCLES - 1);
  localparam logic [CNT_W-1:0] RLD_250 = CNT_W'(2 * POLL_CYCLES - 1);
  localparam logic [CNT_W-1:0] RLD_300 = CNT_W'(POLL_CYCLES * 5 / 3 - 1);
  localparam logic [CNT_W-1:0] RLD_1M = CNT_W'(POLL_CYCLES / 2 - 1);
  localparam logic [PD_W-1:0] PD_TGT = PD_W'(fdcp_pkg::PDOWN_POLLS);
  localparam logic [PD_W-1:0] PD_TGT_1M = PD_W'(2 * fdcp_pkg::PDOWN_POLLS);

  localparam fdcp_regs_s REGS_RST = '{
    state: fdcp_pkg::ST_IDLE,
    poll_cnt: RLD_500,
    drv: 2'h0,
    pd_cnt: '0,
    rdy_chg: fdcp_pkg::RDY_CHG_RST,
    irq: 1'b0,
    step: 1'b0,
    dir: 1'b0,
    stat: fdcp_pkg::STAT_IDLE,
    pdown: 1'b0,
    irq_drv: 2'h0,
    sep_ref: 1'b1,
    filt: fdcp_pkg::FILT_RST
  };

  fdcp_regs_s regs_r;
  fdcp_regs_s regs_nxt;
  logic [CNT_W-1:0] reload;
  logic [PD_W-1:0] pd_target;
  logic pd_arm;
  logic pd_go;

  ////////////////////////////////////////////////////////////////////////////
  // Rate dependent reload and power down target
  always_comb begin
    case (RATE_SEL_I)
      fdcp_pkg::RATE_250K: reload = RLD_250;
      fdcp_pkg::RATE_300K: reload = RLD_300;
      fdcp_pkg::RATE_1M: reload = RLD_1M;
      default: reload = RLD_500;
    endcase
    // 1 Mb/s polls twice as often
    pd_target = (RATE_SEL_I == fdcp_pkg::RATE_1M) ? PD_TGT_1M : PD_TGT;
    pd_arm = AUTO_PDOWN_EN_I & MOTOR_OFF_EXPIRED_I;
    pd_go = pd_arm & (regs_r.pd_cnt >= pd_target);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    regs_nxt = regs_r;
    regs_nxt.step = 1'b0;
    case (regs_r.state)
      fdcp_pkg::ST_IDLE: begin
        if (OPCODE_WR_I) begin
          regs_nxt.state = fdcp_pkg::ST_CMD;
          regs_nxt.pd_cnt = '0;
        end else if (pd_go) begin
          regs_nxt.state = fdcp_pkg::ST_PDOWN;
        end else if (regs_r.poll_cnt == '0) begin
          regs_nxt.state = fdcp_pkg::ST_POLL;
          regs_nxt.drv = 2'h0;
        end else begin
          regs_nxt.poll_cnt = regs_r.poll_cnt - 1'b1;
        end
      end
      fdcp_pkg::ST_POLL: begin
        if (regs_r.rdy_chg[regs_r.drv] && !POLL_DISABLE_I) begin
          regs_nxt.irq = 1'b1;
          regs_nxt.irq_drv = 2'h0;
        end
        // stepping runs whatever the poll setting
        if (STEP_REQ_I[regs_r.drv]) begin
          regs_nxt.step = 1'b1;
          regs_nxt.dir = STEP_DIR_I[regs_r.drv];
        end
        regs_nxt.drv = regs_r.drv + 1'b1;
        if (OPCODE_WR_I) begin
          regs_nxt.state = fdcp_pkg::ST_CMD;
          regs_nxt.pd_cnt = '0;
        end else if (regs_r.drv == 2'h3) begin
          regs_nxt.state = fdcp_pkg::ST_IDLE;
          regs_nxt.poll_cnt = reload;
          regs_nxt.pd_cnt = pd_arm ? regs_r.pd_cnt + 1'b1 : '0;
        end
      end
      fdcp_pkg::ST_CMD: begin
        if (CMD_DONE_I) begin
          regs_nxt.state = fdcp_pkg::ST_IDLE;
          regs_nxt.poll_cnt = reload;
        end
      end
      fdcp_pkg::ST_PDOWN: begin
        // recovery from power down enters idle
        if (PDOWN_RECOVER_I) begin
          regs_nxt.state = fdcp_pkg::ST_IDLE;
          regs_nxt.poll_cnt = reload;
          regs_nxt.pd_cnt = '0;
        end
      end
      default: begin
        regs_nxt.state = fdcp_pkg::ST_IDLE;
      end
    endcase
    regs_nxt.rdy_chg = regs_r.rdy_chg & ~RDY_CHG_CLR_I;
    if (SOFT_RESET_I) begin
      // software reset enters idle; set wins over clear
      regs_nxt.state = fdcp_pkg::ST_IDLE;
      regs_nxt.poll_cnt = reload;
      regs_nxt.pd_cnt = '0;
      regs_nxt.rdy_chg = fdcp_pkg::RDY_CHG_RST;
      regs_nxt.irq = 1'b0;
      regs_nxt.step = 1'b0;
    end else if (regs_nxt.rdy_chg == 4'h0) begin
      regs_nxt.irq = 1'b0;
    end
    // status flags per phase; bit 7 and bit 4
    case (regs_nxt.state)
      fdcp_pkg::ST_IDLE: regs_nxt.stat = fdcp_pkg::STAT_IDLE;
      fdcp_pkg::ST_POLL: regs_nxt.stat = fdcp_pkg::STAT_IDLE;
      fdcp_pkg::ST_CMD: regs_nxt.stat = fdcp_pkg::STAT_CMD;
      default: regs_nxt.stat = fdcp_pkg::STAT_PDOWN;
    endcase
    // Power down flag registered with the phase
    regs_nxt.pdown = (regs_nxt.state == fdcp_pkg::ST_PDOWN);
    // reference lock outside commands; forced relock
    regs_nxt.sep_ref = (regs_nxt.state != fdcp_pkg::ST_CMD) |
                       (ID_SEARCH_I & NON_PREAMBLE_LOCK_I);
    regs_nxt.filt = 4'h1 << RATE_SEL_I;
  end

  ////////////////////////////////////////////////////////////////////////////
  // single clock register stage
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      regs_r <= REGS_RST;
    end else begin
      regs_r <= regs_nxt;
    end
  end

  // Outputs straight from the state register
  assign MAIN_STATUS_O = regs_r.stat;
  assign PHASE_O = regs_r.state;
  assign READY_CHANGED_O = regs_r.rdy_chg;
  assign POLL_IRQ_O = regs_r.irq;
  assign IRQ_DRIVE_O = regs_r.irq_drv;
  assign STEP_O = regs_r.step;
  assign DIR_O = regs_r.dir;
  assign PDOWN_O = regs_r.pdown;
  assign SEP_REF_LOCK_O = regs_r.sep_ref;
  assign FILTER_SEL_O = regs_r.filt;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_idle_flags: assert property (
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    regs_r.state == fdcp_pkg::ST_IDLE |->
      MAIN_STATUS_O[fdcp_pkg::STAT_REQ_BIT] &&
      !MAIN_STATUS_O[fdcp_pkg::STAT_DIR_BIT])
    else $error("Idle status flags wrong");

  a_opcode_cmd: assert property (
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    regs_r.state == fdcp_pkg::ST_IDLE && OPCODE_WR_I && !SOFT_RESET_I
      |=> regs_r.state == fdcp_pkg::ST_CMD &&
          !MAIN_STATUS_O[fdcp_pkg::STAT_REQ_BIT])
    else $error("Opcode did not start command");

  a_done_idle: assert property (
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    regs_r.state == fdcp_pkg::ST_CMD && CMD_DONE_I
      |=> regs_r.state == fdcp_pkg::ST_IDLE)
    else $error("Command end did not return to idle");

  a_soft_reset: assert property (
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    SOFT_RESET_I |=> regs_r.state == fdcp_pkg::ST_IDLE &&
      READY_CHANGED_O == fdcp_pkg::RDY_CHG_RST && !POLL_IRQ_O)
    else $error("Soft reset not honoured");

  a_idle_sepref: assert property (
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    regs_r.state == fdcp_pkg::ST_IDLE |-> SEP_REF_LOCK_O)
    else $error("Separator not on reference while idle");

  a_poll_entry: assert property (
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    regs_r.state == fdcp_pkg::ST_IDLE && regs_r.poll_cnt == '0 &&
      !OPCODE_WR_I && !SOFT_RESET_I && !pd_go
      |=> regs_r.state == fdcp_pkg::ST_POLL && regs_r.drv == 2'h0)
    else $error("Polling phase not entered");

  a_poll_walk: assert property (
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    regs_r.state == fdcp_pkg::ST_POLL && regs_r.drv != 2'h3 &&
      !OPCODE_WR_I && !SOFT_RESET_I
      |=> regs_r.state == fdcp_pkg::ST_POLL &&
          regs_r.drv == 2'($past(regs_r.drv) + 2'h1))
    else $error("Polling phase cut short");

  a_poll_exit: assert property (
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    regs_r.state == fdcp_pkg::ST_POLL && regs_r.drv == 2'h3 &&
      !OPCODE_WR_I && !SOFT_RESET_I |=> regs_r.state == fdcp_pkg::ST_IDLE)
    else $error("Polling phase did not return to idle");

  a_poll_irq: assert property (
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    regs_r.state == fdcp_pkg::ST_POLL && regs_r.rdy_chg[regs_r.drv] &&
      !POLL_DISABLE_I && !SOFT_RESET_I && RDY_CHG_CLR_I == 4'h0
      |=> POLL_IRQ_O && IRQ_DRIVE_O == 2'h0)
    else $error("Ready change not reported");

  a_no_poll_irq: assert property (
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    !POLL_IRQ_O && POLL_DISABLE_I |=> !POLL_IRQ_O)
    else $error("Interrupt raised with polling disabled");

  a_step_dir: assert property (
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    regs_r.state == fdcp_pkg::ST_POLL && STEP_REQ_I[regs_r.drv] &&
      !SOFT_RESET_I
      |=> STEP_O && DIR_O == $past(STEP_DIR_I[regs_r.drv]) ##1 !STEP_O ||
          regs_r.state == fdcp_pkg::ST_POLL)
    else $error("Step pulse or direction wrong");

  a_step_in_poll: assert property (
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    STEP_O |-> $past(regs_r.state == fdcp_pkg::ST_POLL))
    else $error("Step pulse outside polling");

  a_pdown_go: assert property (
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    regs_r.state == fdcp_pkg::ST_IDLE && pd_go && !OPCODE_WR_I &&
      !SOFT_RESET_I |=> PDOWN_O && MAIN_STATUS_O == fdcp_pkg::STAT_PDOWN)
    else $error("Power down not taken");

  a_filter_sel: assert property (
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    ##1 FILTER_SEL_O == (4'h1 << $past(RATE_SEL_I)))
    else $error("Filter does not follow rate");

  a_relock: assert property (
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    ID_SEARCH_I && NON_PREAMBLE_LOCK_I |=> SEP_REF_LOCK_O)
    else $error("No relock on non-preamble pattern");

endmodule

/* tb/fdcp_host_model.sv */
// Host side model for the polling sequencer bench
`timescale 1ns/10ps
module fdcp_host_model (
  input wire logic clk_i,
  input wire logic irq_i,
  input wire logic clr_en_i,
  input wire logic dis_req_i,
  output logic [3:0] clr_o,
  output logic dis_o
);
  logic [1:0] drv = 2'h0;
  always @(negedge clk_i) begin
    dis_o <= dis_req_i;
    clr_o <= (irq_i && clr_en_i) ? 4'h1 << drv : 4'h0;
    if (irq_i && clr_en_i) begin
      drv <= drv + 2'h1;
    end
  end
endmodule

/* tb/fdc_idle_drive_polling_sequencer_tb_top.sv */
// Self-checking bench of the idle and drive polling sequencer
`timescale 1ns/10ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
  error_cnt++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module fdc_idle_drive_polling_sequencer_tb_top;
  localparam int P = 20;
  logic clk = 0;
  logic rst = 1;
  logic srst = 0, rec = 0, opw = 0, done = 0, dis = 0, clr_en = 0;
  logic auto_pd = 0, moff = 0, ids = 0, npl = 0, pdis;
  logic [1:0] rate = 2'h0;
  logic [1:0] irqd;
  logic [3:0] sreq = 4'h0, sdir = 4'h0, clr, ph, rc, filt, pv;
  logic [7:0] mstat;
  logic irq, step, dir, pd, sref;
  int error_cnt = 0, num_checks = 0, n, m, i;
  int exp_q[$] = '{P + 4, 5 * P / 3 + 4, 2 * P + 4, P / 2 + 4};

  fdcp_idle_poll #(.POLL_CYCLES(P)) dut (
    .SYS_CLK_I(clk), .RESET_I(rst), .SOFT_RESET_I(srst),
    .PDOWN_RECOVER_I(rec), .OPCODE_WR_I(opw), .CMD_DONE_I(done),
    .RATE_SEL_I(rate), .POLL_DISABLE_I(pdis), .AUTO_PDOWN_EN_I(auto_pd),
    .MOTOR_OFF_EXPIRED_I(moff), .STEP_REQ_I(sreq), .STEP_DIR_I(sdir),
    .RDY_CHG_CLR_I(clr), .ID_SEARCH_I(ids), .NON_PREAMBLE_LOCK_I(npl),
    .MAIN_STATUS_O(mstat), .PHASE_O(ph), .READY_CHANGED_O(rc),
    .POLL_IRQ_O(irq), .IRQ_DRIVE_O(irqd), .STEP_O(step), .DIR_O(dir),
    .PDOWN_O(pd), .SEP_REF_LOCK_O(sref), .FILTER_SEL_O(filt));

  fdcp_host_model host (.clk_i(clk), .irq_i(irq), .clr_en_i(clr_en),
    .dis_req_i(dis), .clr_o(clr), .dis_o(pdis));

  ////////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    forever #4 clk = ~clk;
  end

  // Count summary, verdict and end of run
  task give_verdict;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Bounded wait ran out
  task fail(input string s, input int e, input int g);
    error_cnt++;
    $display("BAD %s exp %0h got %0h", s, e, g);
    give_verdict;
  endtask

  // Wait for a phase code within a cycle bound
  task wait_ph(input logic [3:0] p, input int lim);
    for (i = 0; i < lim && ph !== p; i++) @(negedge clk);
    if (ph !== p) fail("phase", p, ph);
  endtask

  // Cycles from one poll entry to the next, ends at an entry
  task gap(output int c);
    wait_ph(4'h2, 200);
    pv = ph;
    for (c = 1; c < 200; c++) begin
      @(negedge clk);
      if (ph === 4'h2 && pv !== 4'h2) break;
      pv = ph;
    end
    if (c >= 200) fail("poll gap", 0, c);
  endtask

  // One-cycle strobe from a falling edge
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(32'h542dbbc3));
    repeat (10) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    `CHK("status", 8'h80, mstat)
    `CHK("phase", 4'h1, ph)
    `CHK("rdy_chg", 4'hf, rc)
    `CHK("filter", 4'h1, filt)
    `CHK("sep_ref", 1'b1, sref)
    $display("test reset done");
    wait_ph(4'h2, 100);
    @(negedge clk);
    `CHK("irq", 1'b1, irq)
    `CHK("irq_drv", 2'h0, irqd)
    clr_en = 1'b1;
    repeat (8) @(negedge clk);
    gap(n);
    repeat (6) @(negedge clk);
    `CHK("rdy_chg", 4'h0, rc)
    `CHK("irq", 1'b0, irq)
    $display("test ready changed done");
    for (int r = 0; r < 4; r++) begin
      rate = r[1:0];
      gap(n);
      gap(n);
      `CHK("gap", exp_q[r], n)
      `CHK("filter", 4'h1 << r, filt)
    end
    rate = 2'h0;
    $display("test rates done");
    dis = 1'b1;
    clr_en = 1'b0;
    pulse(srst);
    `CHK("rdy_chg", 4'hf, rc)
    sreq = 4'h4;
    sdir = 4'($urandom());
    gap(n);
    n = 0;
    m = 0;
    repeat (6) begin
      @(negedge clk);
      if (step === 1'b1) n++;
      if (irq === 1'b1) m++;
    end
    `CHK("steps", 1, n)
    `CHK("dir", sdir[2], dir)
    `CHK("irq", 0, m)
    sreq = 4'h0;
    dis = 1'b0;
    clr_en = 1'b1;
    $display("test step done");
    gap(n);
    repeat (5) @(negedge clk);
    ids = 1'b1;
    pulse(opw);
    `CHK("phase", 4'h4, ph)
    `CHK("status", 8'h10, mstat)
    `CHK("sep_ref", 1'b0, sref)
    npl = 1'b1;
    @(negedge clk);
    `CHK("sep_ref", 1'b1, sref)
    npl = 1'b0;
    ids = 1'b0;
    repeat ($urandom_range(1, 5)) @(negedge clk);
    pulse(done);
    `CHK("phase", 4'h1, ph)
    `CHK("status", 8'h80, mstat)
    $display("test command done");
    gap(n);
    wait_ph(4'h1, 10);
    auto_pd = 1'b1;
    moff = 1'b1;
    n = 0;
    for (int k = 0; k < 20000 && ph !== 4'h8; k++) begin
      pv = ph;
      @(negedge clk);
      if (ph === 4'h2 && pv !== 4'h2) n++;
    end
    if (ph !== 4'h8) fail("pdown wait", 8, ph);
    `CHK("polls", 512, n)
    `CHK("status", 8'h00, mstat)
    `CHK("pdown", 1'b1, pd)
    pulse(opw);
    `CHK("phase", 4'h8, ph)
    auto_pd = 1'b0;
    pulse(rec);
    `CHK("phase", 4'h1, ph)
    `CHK("status", 8'h80, mstat)
    $display("test power down done");
    give_verdict;
  end
endmodule
